// [flash_array_model.sv]
// Purpose: Flash array stand-in answering each command with done
// Assumes: One command in flight at a time
// Notes: Slow mode stretches the busy time
`timescale 1ns/1ps
module flash_array_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic slow,
    input flash_guard_pkg::flash_cmd_t cmd,
    output logic flash_done
);
    // ----
    // Busy counter
    // ----
    // Supply monitor taken as always on, so no error reset
    logic [4:0] cnt;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 5'h00;
            flash_done <= 1'b0;
        end else begin
            flash_done <= (cnt == 5'h01);
            if (cmd.start)
                cnt <= slow ? 5'h14 : 5'h01;
            else if (cnt != 5'h00)
                cnt <= cnt - 5'h01;
        end
    end
endmodule

// [flash_guard_checker.sv]
// Purpose: Port-level assertions for the flash write/erase guard
// Assumes: Single clock, async active-low reset
// Notes: Bound from the testbench top file
`timescale 1ns/1ps
module flash_guard_checker (
    input wire logic clk,
    input wire logic resetn,
    input flash_guard_pkg::sfr_req_t sfr,
    input wire logic [7:0] sfr_rdata,
    input wire logic ext_write,
    input wire logic [15:0] ext_addr,
    input wire logic [7:0] ext_wdata,
    input wire logic flash_done,
    input wire logic ext_write_to_flash,
    input wire logic code_read_scratchpad,
    input flash_guard_pkg::flash_cmd_t flash_cmd,
    input wire logic [1:0] lock_code
);
    // ----
    // Key sequence, command and register read checks
    // ----
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence key_a;
        sfr.wr && sfr.addr == 8'hB6 && sfr.wdata == 8'hA5 && lock_code == 2'h0 && !ext_write;
    endsequence
    sequence key_f;
        sfr.wr && sfr.addr == 8'hB6 && sfr.wdata == 8'hF1 && !ext_write && !flash_done;
    endsequence
    sequence key_gap;
        !sfr.wr && !ext_write;
    endsequence
    // Bench spaces key writes by one idle cycle
    a_key_unlock: assert property (key_a ##1 key_gap ##1 key_f |=> lock_code == 2'h2)
        else $error("unlock missed");
    a_bad_key: assert property (sfr.wr && sfr.addr == 8'hB6 && !(lock_code == 2'h0 && sfr.wdata == 8'hA5)
        && !(lock_code == 2'h1 && sfr.wdata == 8'hF1) |=> lock_code == 2'h3) else $error("bad key kept");
    a_lock_sticks: assert property (lock_code == 2'h3 |=> lock_code == 2'h3)
        else $error("lock lost");
    a_bad_attempt: assert property (ext_write && ext_write_to_flash && lock_code != 2'h2 && !sfr.wr
        |=> lock_code == 2'h3 && !flash_cmd.start) else $error("attempt not locked");
    a_done_relock: assert property (flash_done && lock_code == 2'h2 && !sfr.wr |=> lock_code == 2'h0)
        else $error("no relock");
    a_start_gate: assert property (flash_cmd.start |-> $past(lock_code) == 2'h2 && $past(ext_write)
        && $past(ext_write_to_flash)) else $error("start ungated");
    a_cmd_fields: assert property (flash_cmd.start |-> flash_cmd.addr == $past(ext_addr)
        && flash_cmd.scratchpad == $past(code_read_scratchpad)
        && (flash_cmd.erase || flash_cmd.data == $past(ext_wdata))) else $error("cmd fields");
    a_erase_data: assert property (flash_cmd.start && flash_cmd.erase |-> flash_cmd.data == 8'h00)
        else $error("erase data");
    a_ctl_read: assert property (sfr.rd && sfr.addr == 8'h8F && !sfr.wr |=> sfr_rdata[7:3] == 5'h00
        && sfr_rdata[2] == code_read_scratchpad && sfr_rdata[0] == ext_write_to_flash) else $error("ctl read");
    a_key_read: assert property (sfr.rd && sfr.addr == 8'hB6 |=> sfr_rdata == {6'h00, $past(lock_code)})
        else $error("key read");
endmodule

// [flash_guard_pkg.sv]
// Purpose: Shared constants and types for the flash write/erase guard
// Assumes: 8-bit special-function register port, one system clock
// Notes: Offsets are the documented register addresses
package flash_guard_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] PROGRAM_STORE_CONTROL_ADDR = 8'h8F;
    localparam logic [7:0] FLASH_UNLOCK_KEY_ADDR = 8'hB6;
    localparam logic [7:0] PROGRAM_STORE_CONTROL_RESET = 8'h00;
    localparam logic [7:0] FLASH_UNLOCK_KEY_RESET = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int STORE_WRITE_ENABLE_BIT = 0;
    localparam int PAGE_ERASE_ENABLE_BIT = 1;
    localparam int SCRATCHPAD_SELECT_BIT = 2;

    // ------------------------------------------------------------
    // Key values and lock state codes
    // ------------------------------------------------------------
    localparam logic [7:0] FIRST_KEY = 8'hA5;
    localparam logic [7:0] SECOND_KEY = 8'hF1;
    localparam logic [1:0] LOCK_CODE_LOCKED = 2'h0;
    localparam logic [1:0] LOCK_CODE_FIRST = 2'h1;
    localparam logic [1:0] LOCK_CODE_UNLOCKED = 2'h2;
    localparam logic [1:0] LOCK_CODE_PERMANENT = 2'h3;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LOCKED,
        FIRST_KEY_SEEN,
        UNLOCKED,
        PERMANENT
    } lock_state_t;

    typedef struct packed {
        logic scratchpad_select;
        logic page_erase_enable;
        logic store_write_enable;
    } control_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

    typedef struct packed {
        logic start;
        logic erase;
        logic scratchpad;
        logic [15:0] addr;
        logic [7:0] data;
    } flash_cmd_t;

endpackage

// [flash_op_launcher.sv]
// Purpose: Registers one flash program or erase command toward the array
// Assumes: Array completes each command and reports done
// Notes: Erase carries no data; the byte is forced to zero
`timescale 1ns/1ps

module flash_op_launcher (
    input wire logic clk,
    input wire logic resetn,
    input wire logic launch,
    input wire logic erase,
    input wire logic scratchpad,
    input wire logic [15:0] addr,
    input wire logic [7:0] data,
    output flash_guard_pkg::flash_cmd_t cmd
);

    flash_guard_pkg::flash_cmd_t state;
    flash_guard_pkg::flash_cmd_t next_state;

    // ------------------------------------------------------------
    // Command register
    // ------------------------------------------------------------
    always_comb begin
        next_state = '0;
        if (launch) begin
            next_state.start = 1'b1;
            next_state.erase = erase;
            next_state.scratchpad = scratchpad;
            next_state.addr = addr;
            // Data byte dropped on erase
            next_state.data = erase ? 8'h00 : data;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign cmd = state;

endmodule

// [flash_write_erase_guard.sv]
// Purpose: Flash write/erase control with two-byte unlock key
// Assumes: CPU drives SFR strobes and external-space writes synchronously
`timescale 1ns/1ps

module flash_write_erase_guard (
    input wire logic clk,
    input wire logic resetn,
    input flash_guard_pkg::sfr_req_t sfr,
    output logic [7:0] sfr_rdata,
    input wire logic ext_write,
    input wire logic [15:0] ext_addr,
    input wire logic [7:0] ext_wdata,
    input wire logic flash_done,
    output logic ext_write_to_flash,
    output logic code_read_scratchpad,
    output flash_guard_pkg::flash_cmd_t flash_cmd,
    output logic [1:0] lock_code
);

    typedef struct packed {
        flash_guard_pkg::control_t ctrl;
        flash_guard_pkg::lock_state_t lock;
        logic busy;
        logic [7:0] rdata;
    } guard_state_t;

    guard_state_t state;
    guard_state_t next_state;
    logic flash_write;
    logic launch;

    function automatic logic [1:0] lock_to_code(input flash_guard_pkg::lock_state_t s);
        unique case (s)
            flash_guard_pkg::LOCKED: lock_to_code = flash_guard_pkg::LOCK_CODE_LOCKED;
            flash_guard_pkg::FIRST_KEY_SEEN: lock_to_code = flash_guard_pkg::LOCK_CODE_FIRST;
            flash_guard_pkg::UNLOCKED: lock_to_code = flash_guard_pkg::LOCK_CODE_UNLOCKED;
            flash_guard_pkg::PERMANENT: lock_to_code = flash_guard_pkg::LOCK_CODE_PERMANENT;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Write path decode
    // ------------------------------------------------------------
    assign ext_write_to_flash = state.ctrl.store_write_enable;
    assign flash_write = ext_write && state.ctrl.store_write_enable;
    // Busy blocks a second launch until the array reports done
    assign launch = flash_write && !state.busy && state.lock == flash_guard_pkg::UNLOCKED;
    assign code_read_scratchpad = state.ctrl.scratchpad_select;
    assign sfr_rdata = state.rdata;
    assign lock_code = lock_to_code(state.lock);

    // ------------------------------------------------------------
    // Registers and lock sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_state.rdata = 8'h00;
        if (flash_done) begin
            next_state.busy = 1'b0;
            if (state.lock == flash_guard_pkg::UNLOCKED) begin
                next_state.lock = flash_guard_pkg::LOCKED;
            end
        end
        if (launch) begin
            next_state.busy = 1'b1;
        end else if (flash_write && state.lock != flash_guard_pkg::UNLOCKED) begin
            next_state.lock = flash_guard_pkg::PERMANENT;
        end
        if (sfr.wr && sfr.addr == flash_guard_pkg::PROGRAM_STORE_CONTROL_ADDR) begin
            // Upper bits discarded on write
            next_state.ctrl.store_write_enable = sfr.wdata[flash_guard_pkg::STORE_WRITE_ENABLE_BIT];
            next_state.ctrl.page_erase_enable = sfr.wdata[flash_guard_pkg::PAGE_ERASE_ENABLE_BIT];
            next_state.ctrl.scratchpad_select = sfr.wdata[flash_guard_pkg::SCRATCHPAD_SELECT_BIT];
        end
        if (sfr.wr && sfr.addr == flash_guard_pkg::FLASH_UNLOCK_KEY_ADDR) begin
            unique case (state.lock)
                flash_guard_pkg::LOCKED: begin
                    // Any other first byte locks for good
                    next_state.lock = (sfr.wdata == flash_guard_pkg::FIRST_KEY) ?
                        flash_guard_pkg::FIRST_KEY_SEEN : flash_guard_pkg::PERMANENT;
                end
                flash_guard_pkg::FIRST_KEY_SEEN: begin
                    next_state.lock = (sfr.wdata == flash_guard_pkg::SECOND_KEY) ?
                        flash_guard_pkg::UNLOCKED : flash_guard_pkg::PERMANENT;
                end
                flash_guard_pkg::UNLOCKED: next_state.lock = flash_guard_pkg::PERMANENT;
                flash_guard_pkg::PERMANENT: next_state.lock = flash_guard_pkg::PERMANENT;
            endcase
        end
        if (sfr.rd) begin
            if (sfr.addr == flash_guard_pkg::PROGRAM_STORE_CONTROL_ADDR) begin
                next_state.rdata = {5'h00, state.ctrl.scratchpad_select, state.ctrl.page_erase_enable,
                    state.ctrl.store_write_enable};
            end else if (sfr.addr == flash_guard_pkg::FLASH_UNLOCK_KEY_ADDR) begin
                next_state.rdata = {6'h00, lock_to_code(state.lock)};
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state.ctrl <= flash_guard_pkg::control_t'(3'h0);
            state.lock <= flash_guard_pkg::LOCKED;
            state.busy <= 1'b0;
            state.rdata <= 8'h00;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Array command
    // ------------------------------------------------------------
    flash_op_launcher launcher (
        .clk(clk),
        .resetn(resetn),
        .launch(launch),
        .erase(state.ctrl.page_erase_enable),
        .scratchpad(state.ctrl.scratchpad_select),
        .addr(ext_addr),
        .data(ext_wdata),
        .cmd(flash_cmd)
    );

endmodule

// [flash_write_erase_guard_tb_top.sv]
// Purpose: Self-checking bench for the flash write/erase guard
// Assumes: Inputs change on the falling edge
// Notes: Seeded random addresses and data
`timescale 1ns/1ps
module flash_write_erase_guard_tb_top;
    // ----
    // Stimulus and checks
    // ----
    logic clk = 0, resetn = 0, ext_write = 0, slow = 0, flash_done, ext_write_to_flash, code_read_scratchpad;
    flash_guard_pkg::sfr_req_t sfr = '0;
    flash_guard_pkg::flash_cmd_t flash_cmd, cmd_seen;
    logic [15:0] ext_addr = 16'h0000;
    logic [7:0] ext_wdata = 8'h00, sfr_rdata, seen, ctl;
    logic [7:0] tbl [4] = '{8'h03, 8'h01, 8'h07, 8'h05}; // Erase before program
    logic [1:0] lock_code;
    integer errors = 0, checks = 0, seed = 99033;
    always #12.5 clk = ~clk;
    flash_write_erase_guard dut (.clk(clk), .resetn(resetn), .sfr(sfr), .sfr_rdata(sfr_rdata),
        .ext_write(ext_write), .ext_addr(ext_addr), .ext_wdata(ext_wdata), .flash_done(flash_done),
        .ext_write_to_flash(ext_write_to_flash), .code_read_scratchpad(code_read_scratchpad),
        .flash_cmd(flash_cmd), .lock_code(lock_code));
    flash_array_model array (.clk(clk), .resetn(resetn), .slow(slow), .cmd(flash_cmd), .flash_done(flash_done));
    task complete_run;
        if (errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (e !== g) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task sfr_op(input logic wr, input logic [7:0] a, input logic [7:0] d);
        sfr.wr = wr;
        sfr.rd = !wr;
        sfr.addr = a;
        sfr.wdata = d;
        @(negedge clk);
        sfr = '0;
        seen = sfr_rdata;
        @(negedge clk);
    endtask
    task ext_op(input logic [15:0] a, input logic [7:0] d);
        ext_write = 1;
        ext_addr = a;
        ext_wdata = d;
        @(negedge clk);
        ext_write = 0;
        cmd_seen = flash_cmd;
        @(negedge clk);
    endtask
    function flash_guard_pkg::flash_cmd_t exp_cmd(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d);
        return {1'b1, c[1], c[2], a, c[1] ? 8'h00 : d};
    endfunction
    initial begin
        #100000;
        errors++;
        complete_run;
    end
    initial begin
        repeat (2) @(negedge clk);
        resetn = 1;
        sfr_op(0, 8'h8F, 8'h00); chk("ctl reset", 0, seen);
        sfr_op(0, 8'h55, 8'h00); chk("unmapped", 0, seen);
        sfr_op(1, 8'h8F, 8'hFF); sfr_op(0, 8'h8F, 8'h00); chk("ctl read", 8'h07, seen);
        chk("steering", 2'b11, {code_read_scratchpad, ext_write_to_flash});
        for (int k = 0; k < 4; k++) begin
            ctl = tbl[k];
            sfr_op(1, 8'h8F, ctl);
            sfr_op(1, 8'hB6, 8'hA5); chk("key one", 1, seen | lock_code);
            sfr_op(1, 8'hB6, 8'hF1); sfr_op(0, 8'hB6, 8'h00); chk("key two", 2, seen);
            ext_addr = $random(seed) & (ctl[2] ? 16'h03FF : 16'hFFFF); // Scratchpad range
            slow = k[0];
            ext_op(ext_addr, $random(seed)); chk("command", exp_cmd(ctl, ext_addr, ext_wdata), cmd_seen);
            for (int i = 0; i < 40 && lock_code !== 2'h0; i++) @(negedge clk);
            chk("relock", 0, lock_code);
        end
        sfr_op(1, 8'h8F, 8'h00); ext_op($random(seed), 8'h5A); chk("write off", 0, {cmd_seen.start, lock_code});
        sfr_op(1, 8'h8F, 8'h01); ext_op($random(seed), 8'h5A); chk("locked try", 3, {cmd_seen.start, lock_code});
        for (int k = 0; k < 2; k++) begin
            resetn = 0;
            @(negedge clk);
            resetn = 1;
            chk("reset state", 0, {lock_code, code_read_scratchpad, ext_write_to_flash});
            seen = $random(seed);
            sfr_op(1, 8'hB6, k ? 8'hA5 : (seen == 8'hA5 ? 8'h00 : seen)); // Wrong first key locks when k is 0; k of 1 sends the right first key
            sfr_op(1, 8'hB6, 8'hA5); chk("wrong key", 3, lock_code);
        end
        complete_run;
    end
endmodule
bind flash_write_erase_guard flash_guard_checker chk_i (.clk(clk), .resetn(resetn), .sfr(sfr),
    .sfr_rdata(sfr_rdata), .ext_write(ext_write), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
    .flash_done(flash_done), .ext_write_to_flash(ext_write_to_flash),
    .code_read_scratchpad(code_read_scratchpad), .flash_cmd(flash_cmd), .lock_code(lock_code));
